// file: hw/iar_alarm_router.v
// Interface alarm routing, idle timers, event logging and loopbacks with AXI4-Lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "iar_regs.vh"
// Notes on behaviour
// R1: Hardware alarm event setting 1 logs each status change, 2 logs and sends an alert.
// R2: An event setting of 0 keeps status changes of that source out of the log.
// R3: The three-bit I/O routing field sends the alarm to A (1), B (2), both (3) or nowhere (0).
// R4: I/O routing settings 4 to 7 also mute the transmit carrier while the I/O alarm is on.
// R5: Send-data routing takes 0 to 3 for none, A, B or both.
// R6: Send-data alarm rises after the programmed seconds of no transmit data; 0 disables it.
// R7: Receive-data routing takes 0 to 3 for none, A, B or both.
// R8: Receive-data alarm rises after the programmed 0 to 9999 idle seconds; 0 disables it.
// R9: Test-active and hardware sources each route 0 to 3: none, A, B or both.
// R10: Satellite loopback 1 returns satellite receive input onto the send output.
// R11: Terrestrial loopback 1 returns terrestrial send input onto the receive output.
// R12: Each alarm output is the OR of routed active sources; idle timers restart on activity.
module iar_alarm_router
#(
    parameter SEC_CYCLES = `IAR_SEC_CYCLES
)
(
    input  wire        clk,
    input  wire        sys_rst,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Alarm sources from pins
    input  wire        ioAlarmIn,
    input  wire        testActiveIn,
    input  wire        hwAlarmIn,
    input  wire        sendActivityIn,
    input  wire        rcvActivityIn,
    // Data paths
    input  wire        terSendDataIn,
    input  wire        satRcvDataIn,
    output reg         satSendDataOut,
    output reg         terRcvDataOut,
    // Alarm and event outputs
    output reg         alarmAOut,
    output reg         alarmBOut,
    output reg         transmitCarrierMute,
    output reg         logPulse,
    output reg         alertPulse,
    output reg  [4:0]  logSource,
    output reg         irqOut
);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    reg  [6:0]  syncA_q;
    reg  [6:0]  syncB_q;
    wire [6:0]  pinIn = {satRcvDataIn, terSendDataIn, rcvActivityIn, sendActivityIn,
                         hwAlarmIn, testActiveIn, ioAlarmIn};
    // Two flops per pin; only syncB_q feeds logic
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            syncA_q <= 7'h00;
            syncB_q <= 7'h00;
        end
        else
        begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
        end
    end
    wire ioAlm    = syncB_q[0];
    wire testAlm  = syncB_q[1];
    wire hwAlm    = syncB_q[2];
    wire sendAct  = syncB_q[3];
    wire rcvAct   = syncB_q[4];
    wire terSend  = syncB_q[5];
    wire satRcv   = syncB_q[6];
    // Software-visible settings
    reg  [31:0] route_q;
    reg  [31:0] event_q;
    reg  [13:0] sendIdle_q;
    reg  [13:0] rcvIdle_q;
    reg  [1:0]  test_q;
    reg  [1:0]  irqStat_q;
    reg  [1:0]  irqEn_q;
    // ---------------------------------------------------------------
    // Idle timers: one-second tick and two second counters
    // ---------------------------------------------------------------
    reg  [25:0] tick_q;
    reg  [13:0] sendSec_q;
    reg  [13:0] rcvSec_q;
    reg         sendIdleAlm_q;
    reg         rcvIdleAlm_q;
    wire        secTick = (tick_q == SEC_CYCLES - 1);
    // Shared prescaler keeps both timers on the same second boundary
    always @(posedge clk)
    begin
        if (sys_rst || secTick)
            tick_q <= 26'h000_0000;
        else
            tick_q <= tick_q + 26'h000_0001;
    end
    // Activity restarts the count and clears the alarm
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            sendSec_q     <= 14'h0000;
            rcvSec_q      <= 14'h0000;
            sendIdleAlm_q <= 1'b0;
            rcvIdleAlm_q  <= 1'b0;
        end
        else
        begin
            if (sendAct || sendIdle_q == 14'h0000) // R12
                sendSec_q <= 14'h0000;
            else if (secTick && sendSec_q != sendIdle_q)
                sendSec_q <= sendSec_q + 14'h0001;
            sendIdleAlm_q <= (sendIdle_q != 14'h0000) && !sendAct
                             && (sendSec_q == sendIdle_q); // R6
            if (rcvAct || rcvIdle_q == 14'h0000) // R12
                rcvSec_q <= 14'h0000;
            else if (secTick && rcvSec_q != rcvIdle_q)
                rcvSec_q <= rcvSec_q + 14'h0001;
            rcvIdleAlm_q <= (rcvIdle_q != 14'h0000) && !rcvAct
                            && (rcvSec_q == rcvIdle_q); // R8
        end
    end
    // ---------------------------------------------------------------
    // Routing onto alarm outputs A and B
    // ---------------------------------------------------------------
    wire [4:0] srcAct = {hwAlm, testAlm, rcvIdleAlm_q, sendIdleAlm_q, ioAlm};
    wire [1:0] rtIo   = route_q[`IAR_RT_IO_LSB +: 2]; // R3
    wire [1:0] rtSend = route_q[`IAR_RT_SEND_LSB +: 2]; // R5
    wire [1:0] rtRcv  = route_q[`IAR_RT_RCV_LSB +: 2]; // R7
    wire [1:0] rtTest = route_q[`IAR_RT_TEST_LSB +: 2]; // R9
    wire [1:0] rtHw   = route_q[`IAR_RT_HW_LSB +: 2]; // R9
    wire       toA    = (srcAct[0] & rtIo[0]) | (srcAct[1] & rtSend[0])
                      | (srcAct[2] & rtRcv[0]) | (srcAct[3] & rtTest[0])
                      | (srcAct[4] & rtHw[0]); // R12
    wire       toB    = (srcAct[0] & rtIo[1]) | (srcAct[1] & rtSend[1])
                      | (srcAct[2] & rtRcv[1]) | (srcAct[3] & rtTest[1])
                      | (srcAct[4] & rtHw[1]); // R12
    // ---------------------------------------------------------------
    // Event logging on status change
    // ---------------------------------------------------------------
    reg  [4:0] srcPrev_q;
    wire [4:0] srcChg = srcAct ^ srcPrev_q;
    reg  [4:0] logSel;
    reg  [4:0] alertSel;
    integer    i;
    // Decode of each event setting
    always @*
    begin
        logSel   = 5'h00;
        alertSel = 5'h00;
        for (i = 0; i < 5; i = i + 1)
        begin
            // Setting 0 never logs; 3 is treated as 0
            logSel[i]   = srcChg[i] &&
                          (event_q[2*i +: 2] == `IAR_EV_LOG ||
                           event_q[2*i +: 2] == `IAR_EV_ALERT);       // R2
            alertSel[i] = srcChg[i] && event_q[2*i +: 2] == `IAR_EV_ALERT;
        end
    end
    // Registered outputs
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            srcPrev_q           <= 5'h00;
            alarmAOut           <= 1'b0;
            alarmBOut           <= 1'b0;
            transmitCarrierMute <= 1'b0;
            logPulse            <= 1'b0;
            alertPulse          <= 1'b0;
            logSource           <= 5'h00;
            satSendDataOut      <= 1'b0;
            terRcvDataOut       <= 1'b0;
        end
        else
        begin
            srcPrev_q           <= srcAct;
            alarmAOut           <= toA;
            alarmBOut           <= toB;
            transmitCarrierMute <= ioAlm & route_q[`IAR_RT_MUTE_BIT];  // R4
            logPulse            <= |logSel;                            // R1
            alertPulse          <= |alertSel;                          // R1
            logSource           <= logSel;
            satSendDataOut      <= test_q[`IAR_TS_SATLOOP_BIT] ? satRcv : terSend; // R10
            terRcvDataOut       <= test_q[`IAR_TS_TERLOOP_BIT] ? terSend : satRcv; // R11
        end
    end
    // ---------------------------------------------------------------
    // AXI4-Lite slave
    // ---------------------------------------------------------------
    reg  [7:0]  awAddr_q;
    reg         awHave_q;
    reg  [31:0] wData_q;
    reg  [3:0]  wStrb_q;
    reg         wHave_q;
    wire        doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    reg  [31:0] wMerged;
    reg         wOk;
    // Byte-lane merge of a write into the old value
    function [31:0] merge;
        input [31:0] oldV;
        input [31:0] newV;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1)
                merge[8*k +: 8] = strb[k] ? newV[8*k +: 8] : oldV[8*k +: 8];
        end
    endfunction
    // Address decode of writes
    always @*
    begin
        wMerged = 32'h0000_0000;
        wOk     = 1'b1;
        case (awAddr_q)
            `IAR_OFS_ROUTE:    wMerged = merge(route_q, wData_q, wStrb_q);
            `IAR_OFS_EVENT:    wMerged = merge(event_q, wData_q, wStrb_q);
            `IAR_OFS_SENDIDLE: wMerged = merge({18'h0_0000, sendIdle_q}, wData_q, wStrb_q);
            `IAR_OFS_RCVIDLE:  wMerged = merge({18'h0_0000, rcvIdle_q}, wData_q, wStrb_q);
            `IAR_OFS_TEST:     wMerged = merge({30'h0000_0000, test_q}, wData_q, wStrb_q);
            `IAR_OFS_IRQCLR:   wMerged = wData_q & {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                                                    {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
            `IAR_OFS_IRQEN:    wMerged = merge({30'h0000_0000, irqEn_q}, wData_q, wStrb_q);
            `IAR_OFS_STATUS,
            `IAR_OFS_IRQSTAT:  wMerged = 32'h0000_0000;
            default:           wOk = 1'b0;
        endcase
    end
    // Write channel: AW and W in either order
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            awHave_q      <= 1'b0;
            wHave_q       <= 1'b0;
            awAddr_q      <= 8'h00;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            route_q       <= `IAR_RST_ROUTE;
            event_q       <= `IAR_RST_EVENT;
            sendIdle_q    <= `IAR_RST_IDLE;
            rcvIdle_q     <= `IAR_RST_IDLE;
            test_q        <= `IAR_RST_TEST;
            irqEn_q       <= `IAR_RST_IRQEN;
        end
        else
        begin
            s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wOk ? 2'h0 : 2'h2;
                case (awAddr_q)
                    `IAR_OFS_ROUTE:    route_q    <= wMerged & 32'h0003_3337;
                    `IAR_OFS_EVENT:    event_q    <= wMerged & 32'h0000_03FF;
                    // Low 14 bits of seconds above 9999 clamp to 9999; upper bits are dropped
                    `IAR_OFS_SENDIDLE: sendIdle_q <= (wMerged[13:0] > `IAR_IDLE_MAX) ?
                                                     `IAR_IDLE_MAX : wMerged[13:0];
                    `IAR_OFS_RCVIDLE:  rcvIdle_q  <= (wMerged[13:0] > `IAR_IDLE_MAX) ?
                                                     `IAR_IDLE_MAX : wMerged[13:0];
                    `IAR_OFS_TEST:     test_q     <= wMerged[1:0];
                    `IAR_OFS_IRQEN:    irqEn_q    <= wMerged[1:0];
                    default:           ;
                endcase
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    // Sticky event flags; a new event in the clear cycle wins
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            irqStat_q <= 2'h0;
            irqOut    <= 1'b0;
        end
        else
        begin
            irqStat_q <= (irqStat_q & ~((doWrite && awAddr_q == `IAR_OFS_IRQCLR) ?
                                        wMerged[1:0] : 2'h0))
                         | {|alertSel, |logSel};
            irqOut    <= |(irqStat_q & irqEn_q);
        end
    end
    // Read channel: data one cycle after AR
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case ({s_axi_araddr[7:2], 2'b00})
                    `IAR_OFS_ROUTE:    s_axi_rdata <= route_q;
                    `IAR_OFS_EVENT:    s_axi_rdata <= event_q;
                    `IAR_OFS_SENDIDLE: s_axi_rdata <= {18'h0_0000, sendIdle_q};
                    `IAR_OFS_RCVIDLE:  s_axi_rdata <= {18'h0_0000, rcvIdle_q};
                    `IAR_OFS_TEST:     s_axi_rdata <= {30'h0000_0000, test_q};
                    `IAR_OFS_STATUS:   s_axi_rdata <= {24'h00_0000, transmitCarrierMute,
                                                       alarmBOut, alarmAOut, srcAct};
                    `IAR_OFS_IRQSTAT:  s_axi_rdata <= {30'h0000_0000, irqStat_q};
                    `IAR_OFS_IRQEN:    s_axi_rdata <= {30'h0000_0000, irqEn_q};
                    `IAR_OFS_IRQCLR:   s_axi_rdata <= 32'h0000_0000;
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule // iar_alarm_router

// file: hw/iar_regs.vh
// Offsets, fields, reset values and timing of the alarm router
`ifndef IAR_REGS_VH
`define IAR_REGS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define IAR_OFS_ROUTE      8'h00
`define IAR_OFS_EVENT      8'h04
`define IAR_OFS_SENDIDLE   8'h08
`define IAR_OFS_RCVIDLE    8'h0C
`define IAR_OFS_TEST       8'h10
`define IAR_OFS_STATUS     8'h14
`define IAR_OFS_IRQSTAT    8'h18
`define IAR_OFS_IRQCLR     8'h1C
`define IAR_OFS_IRQEN      8'h20

// ---------------------------------------------------------------
// Field positions (route register)
// ---------------------------------------------------------------
`define IAR_RT_IO_LSB      0
`define IAR_RT_SEND_LSB    4
`define IAR_RT_RCV_LSB     8
`define IAR_RT_TEST_LSB    12
`define IAR_RT_HW_LSB      16
`define IAR_RT_MUTE_BIT    2

// Event register: 2 bits per source, io/send/rcv/test/hw
`define IAR_EV_IO_LSB      0
`define IAR_EV_SEND_LSB    2
`define IAR_EV_RCV_LSB     4
`define IAR_EV_TEST_LSB    6
`define IAR_EV_HW_LSB      8
`define IAR_EV_NOLOG       2'h0
`define IAR_EV_LOG         2'h1
`define IAR_EV_ALERT       2'h2

// Test register bits
`define IAR_TS_SATLOOP_BIT 0
`define IAR_TS_TERLOOP_BIT 1

// Interrupt status bits
`define IAR_IRQ_LOG_BIT    0
`define IAR_IRQ_ALERT_BIT  1

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define IAR_RST_ROUTE      32'h0000_0000
`define IAR_RST_EVENT      32'h0000_0000
`define IAR_RST_IDLE       14'h001E
`define IAR_RST_TEST       2'h0
`define IAR_RST_IRQEN      2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define IAR_CLK_HZ         40000000
`define IAR_SEC_CYCLES     (`IAR_CLK_HZ * 1)
`define IAR_IDLE_MAX       14'h270F

`endif

// file: verif/iar_far_end.sv
// Far-side model: terrestrial sender and satellite receive path
`timescale 1ns/1ps
module iar_far_end
(
    input  wire clk,
    input  wire sendOn,
    input  wire rcvOn,
    output reg  sendActivity = 1'h0,
    output reg  rcvActivity = 1'h0,
    output reg  terSendData = 1'h1,
    output reg  satRcvData = 1'h0
);
    // Live lines toggle; idle at 1 and 0
    always @(posedge clk)
    begin
        sendActivity <= sendOn;
        rcvActivity  <= rcvOn;
        terSendData  <= sendOn ? ~terSendData : 1'h1;
        satRcvData   <= rcvOn ? ~satRcvData : 1'h0;
    end
endmodule // iar_far_end

// file: verif/iar_router_sva.sv
// Port-level checker for the alarm router
`timescale 1ns/1ps
module iar_router_sva
(
    input wire        clk,
    input wire        sys_rst,
    input wire        s_axi_awready,
    input wire        s_axi_arready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        ioAlarmIn,
    input wire        transmitCarrierMute,
    input wire        logPulse,
    input wire        alertPulse,
    input wire [4:0]  logSource,
    input wire        alarmAOut,
    input wire        alarmBOut,
    input wire        irqOut
);
    // ----
    // Assertions
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // Quiet after reset; own disable
    a_reset_quiet: assert property (disable iff (1'h0)
        sys_rst |=> !(alarmAOut | alarmBOut | irqOut | s_axi_bvalid | s_axi_rvalid))
        else $error("active after reset");
    // Pin to mute: 2 sync flops, 1 register
    a_mute_cause: assert property (transmitCarrierMute |-> $past(ioAlarmIn, 3))
        else $error("mute without io alarm");
    a_mute_release: assert property (!ioAlarmIn [*3] |=> !transmitCarrierMute)
        else $error("mute held");
    a_alert_logged: assert property (alertPulse |-> logPulse)
        else $error("alert without log");
    a_log_source: assert property (logPulse |-> logSource != 5'h00)
        else $error("log without source");
    // Answers stand until taken
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("awready in response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready in response");

    // Main scenarios reached
    c_alert: cover property (alertPulse);
    c_mute: cover property (transmitCarrierMute);
    c_irq: cover property (irqOut);
endmodule // iar_router_sva

// file: verif/test_interface_alarm_routing_and_loopback.sv
// Self-checking bench for the alarm router
`timescale 1ns/1ps
`include "iar_regs.vh"
module test_interface_alarm_routing_and_loopback;
    localparam int SEC = 10;
    reg         clk = 1'h0;
    reg         sys_rst = 1'h1;
    reg  [7:0]  awaddr = 8'h00;
    reg         awvalid = 1'h0;
    reg  [31:0] wdata = 32'h0;
    reg         wvalid = 1'h0;
    reg         bready = 1'h0;
    reg  [7:0]  araddr = 8'h00;
    reg         arvalid = 1'h0;
    reg         rready = 1'h0;
    reg         ioIn = 1'h0;
    reg         testIn = 1'h0;
    reg         hwIn = 1'h0;
    reg         sendOn = 1'h1;
    reg         rcvOn = 1'h1;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [4:0]  logSrc;
    wire        sendAct, rcvAct, terData, satData;
    wire        satOut, terOut, alA, alB, mute, logP, alertP, irq;
    int         nErrors = 0;
    int         totalChecks = 0;

    // 40 MHz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    iar_alarm_router #(.SEC_CYCLES(SEC)) dut
    (
        .clk(clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ioAlarmIn(ioIn), .testActiveIn(testIn), .hwAlarmIn(hwIn),
        .sendActivityIn(sendAct), .rcvActivityIn(rcvAct),
        .terSendDataIn(terData), .satRcvDataIn(satData),
        .satSendDataOut(satOut), .terRcvDataOut(terOut),
        .alarmAOut(alA), .alarmBOut(alB), .transmitCarrierMute(mute),
        .logPulse(logP), .alertPulse(alertP), .logSource(logSrc), .irqOut(irq)
    );

    iar_far_end farEnd
    (
        .clk(clk), .sendOn(sendOn), .rcvOn(rcvOn), .sendActivity(sendAct),
        .rcvActivity(rcvAct), .terSendData(terData), .satRcvData(satData)
    );

    // ----
    // Tasks
    // ----
    task automatic finalReport;
        if (nErrors == 0 && totalChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        totalChecks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            nErrors++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // AW and W together, each released when taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'h1;
        wvalid  <= 1'h1;
        bready  <= 1'h1;
        repeat (50)
        begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        check("bvalid", 32'h1, bvalid);
        if (bvalid !== 1'h1) finalReport();
        check("bresp", er, bresp);
    endtask

    // Data unchecked on error
    task automatic axiRead(input string nm, input logic [7:0] a, input logic [31:0] e,
                           input logic [1:0] er);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'h1;
        rready  <= 1'h1;
        repeat (50)
        begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        check("rvalid", 32'h1, rvalid);
        if (rvalid !== 1'h1) finalReport();
        check("rresp", er, rresp);
        if (er == 2'h0) check(nm, e, rdata);
    endtask

    task automatic setSrc(input int s, input logic v);
        if (s == 0) ioIn <= v;
        else if (s == 1) testIn <= v;
        else hwIn <= v;
    endtask

    // OR of {log, alert, source} over 12 cycles
    task automatic watchLog(output logic [6:0] seen);
        seen = 7'h00;
        repeat (12)
        begin
            @(posedge clk);
            seen = seen | {logP, alertP, logSrc & {5{logP}}};
        end
    endtask

    // ----
    // Scenarios
    // ----
    initial
    begin
        int s;
        int k;
        int lsb;
        logic [6:0] seen;
        tick(20);
        sys_rst <= 1'h0;
        axiRead("route", `IAR_OFS_ROUTE, 32'h0, 2'h0);
        axiRead("event", `IAR_OFS_EVENT, 32'h0, 2'h0);
        axiRead("sendIdle", `IAR_OFS_SENDIDLE, 32'h1E, 2'h0);
        axiRead("rcvIdle", `IAR_OFS_RCVIDLE, 32'h1E, 2'h0);
        axiRead("test", `IAR_OFS_TEST, 32'h0, 2'h0);
        axiRead("irqEn", `IAR_OFS_IRQEN, 32'h0, 2'h0);
        axiRead("unmapped", 8'h40, 32'h0, 2'h2);
        axiWrite(8'h40, 32'hFFFF_FFFF, 2'h2);
        // All routing codes, pin sources
        for (s = 0; s < 3; s++)
        begin
            lsb = (s == 0) ? `IAR_RT_IO_LSB : (s == 1) ? `IAR_RT_TEST_LSB : `IAR_RT_HW_LSB;
            for (k = 0; k < ((s == 0) ? 8 : 4); k++)
            begin
                axiWrite(`IAR_OFS_ROUTE, k << lsb, 2'h0);
                setSrc(s, 1'h1);
                tick(6);
                check("alarmAB", k & 3, {alB, alA});
                check("mute", (s == 0) && (k > 3), mute);
                setSrc(s, 1'h0);
                tick(6);
                check("cleared", 32'h0, {alB, alA, mute});
            end
        end
        axiWrite(`IAR_OFS_ROUTE, 32'h0002_0001, 2'h0);
        ioIn <= 1'h1;
        hwIn <= 1'h1;
        tick(6);
        check("orAB", 32'h3, {alB, alA});
        axiRead("status", `IAR_OFS_STATUS, 32'h71, 2'h0);
        ioIn <= 1'h0;
        tick(6);
        check("orAB", 32'h2, {alB, alA});
        hwIn <= 1'h0;
        // Idle timers at 3 s
        axiWrite(`IAR_OFS_SENDIDLE, 32'h0000_0003, 2'h0);
        axiWrite(`IAR_OFS_RCVIDLE, 32'h0000_0003, 2'h0);
        for (s = 0; s < 2; s++)
            for (k = 0; k < 4; k++)
            begin
                lsb = s ? `IAR_RT_RCV_LSB : `IAR_RT_SEND_LSB;
                axiWrite(`IAR_OFS_ROUTE, k << lsb, 2'h0);
                if (s) rcvOn <= 1'h0; else sendOn <= 1'h0;
                tick(12);
                check("early", 32'h0, {alB, alA});
                tick(40);
                check("idleAB", k, {alB, alA});
                sendOn <= 1'h1;
                rcvOn  <= 1'h1;
                tick(8);
                check("restart", 32'h0, {alB, alA});
            end
        axiWrite(`IAR_OFS_SENDIDLE, 32'h0000_0000, 2'h0);
        axiWrite(`IAR_OFS_RCVIDLE, 32'h0000_0000, 2'h0);
        axiWrite(`IAR_OFS_ROUTE, 32'h0000_0210, 2'h0);
        sendOn <= 1'h0;
        rcvOn  <= 1'h0;
        tick(100);
        check("disabled", 32'h0, {alB, alA});
        // Loopbacks; idle lines: ter 1, sat 0
        for (k = 0; k < 4; k++)
        begin
            axiWrite(`IAR_OFS_TEST, k, 2'h0);
            tick(8);
            check("satSend", (k & 1) ? 0 : 1, satOut);
            check("terRcv", (k & 2) ? 1 : 0, terOut);
        end
        axiWrite(`IAR_OFS_TEST, 32'h0000_0000, 2'h0);
        axiWrite(`IAR_OFS_ROUTE, 32'h0000_0000, 2'h0);
        sendOn <= 1'h1;
        rcvOn  <= 1'h1;
        // Logging, alert, irq mask/clear
        axiWrite(`IAR_OFS_EVENT, 32'h0000_0201, 2'h0);
        hwIn <= 1'h1;
        watchLog(seen);
        check("hwEvent", 32'h70, seen);
        check("irqMasked", 32'h0, irq);
        axiRead("irqStat", `IAR_OFS_IRQSTAT, 32'h0000_0003, 2'h0);
        axiWrite(`IAR_OFS_IRQEN, 32'h0000_0003, 2'h0);
        tick(2);
        check("irqOn", 32'h1, irq);
        axiWrite(`IAR_OFS_IRQCLR, 32'h0000_0003, 2'h0);
        tick(2);
        axiRead("irqStat", `IAR_OFS_IRQSTAT, 32'h0000_0000, 2'h0);
        check("irqOff", 32'h0, irq);
        ioIn <= 1'h1;
        watchLog(seen);
        check("ioEvent", 32'h41, seen);
        testIn <= 1'h1;
        watchLog(seen);
        check("testEvent", 32'h0, seen);
        axiRead("irqStat", `IAR_OFS_IRQSTAT, 32'h0000_0001, 2'h0);
        tick(5);
        finalReport();
    end
endmodule // test_interface_alarm_routing_and_loopback

bind iar_alarm_router iar_router_sva u_sva
(
    .clk(clk), .sys_rst(sys_rst), .s_axi_awready(s_axi_awready),
    .s_axi_arready(s_axi_arready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .ioAlarmIn(ioAlarmIn), .transmitCarrierMute(transmitCarrierMute),
    .logPulse(logPulse), .alertPulse(alertPulse), .logSource(logSource),
    .alarmAOut(alarmAOut), .alarmBOut(alarmBOut), .irqOut(irqOut)
);
